// ### lsd_pkg.sv
package lsd_pkg;

  localparam int unsigned LSD_SYS_CLK_HZ    = 125_000_000;
  localparam int unsigned LSD_FAST_LCD_HZ   = 2048;
  localparam int unsigned LSD_SLOW_LCD_HZ   = 128;
  // ticks run at twice the lcd clock so every inversion phase is a whole tick count
  localparam int unsigned LSD_FAST_TICK_CYC = LSD_SYS_CLK_HZ / (2 * LSD_FAST_LCD_HZ);
  localparam int unsigned LSD_SLOW_TICK_CYC = LSD_SYS_CLK_HZ / (2 * LSD_SLOW_LCD_HZ);
  localparam int unsigned LSD_TICK_W        = 20;

  localparam logic [7:0] LSD_ADDR_CFG     = 8'h95;
  localparam logic [7:0] LSD_ADDR_CLK     = 8'h96;
  localparam logic [7:0] LSD_ADDR_SEGE_HI = 8'h97;
  localparam logic [7:0] LSD_ADDR_PTR     = 8'hAC;
  localparam logic [7:0] LSD_ADDR_DAT     = 8'hAE;
  localparam logic [7:0] LSD_ADDR_FRZ     = 8'hB1;
  localparam logic [7:0] LSD_ADDR_SEGE_LO = 8'hED;

  localparam int unsigned LSD_CFG_CLR_BIT    = 6;
  localparam int unsigned LSD_CFG_LCD_CLOCK_SELECT_BIT = 3;
  localparam int unsigned LSD_CFG_BIAS_BIT   = 2;
  localparam int unsigned LSD_PTR_WR_BIT     = 7;
  localparam logic [7:0]  LSD_CFG_MASK       = 8'h0F;
  localparam logic [7:0]  LSD_FD_MASK        = 8'h0F;
  localparam logic [7:0]  LSD_PTR_MASK       = 8'hBF;
  localparam logic [7:0]  LSD_SEGE_HI_MASK   = 8'hFC;
  localparam logic [7:0]  LSD_SEGE_LO_MASK   = 8'h0F;
  localparam logic [7:0]  LSD_FRZ_MASK       = 8'h01;
  localparam logic [7:0]  LSD_REG_RST        = 8'h00;

  localparam int unsigned LSD_MEM_BYTES = 15;
  localparam int unsigned LSD_NUM_SEG   = 29;
  localparam logic [3:0]  LSD_LAST_ADDR = 4'hE;
  localparam logic [7:0]  LSD_DIV_RST   = 8'h80;
  localparam logic [1:0]  LSD_MUX_3X    = 2'b10;
  localparam logic [1:0]  LSD_MUX_4X    = 2'b11;

  function automatic logic [1:0] lsd_last_com(input logic [1:0] mux);
    logic [1:0] r;
    r = (mux == LSD_MUX_4X) ? 2'h3 : ((mux == LSD_MUX_3X) ? 2'h2 : 2'h1);
    return r;
  endfunction

  // inversion phase length in ticks; slow selects the 128 Hz lcd clock
  function automatic logic [7:0] lsd_phase_ticks(input logic       slow,
                                                 input logic [1:0] mux,
                                                 input logic [3:0] fd);
    logic [7:0] n;
    logic [7:0] t;
    n = {4'h0, fd} + 8'h01;
    if (!slow) begin
      if (fd == 4'h0) t = 8'h40;
      else if (mux == LSD_MUX_3X && fd == 4'h1) t = 8'h06;
      else t = {n[6:0], 1'b0};
      if (!mux[1]) t = {t[6:0], 1'b0};
    end else begin
      if (fd == 4'hF) t = 8'h01;
      else if (fd == 4'h0) t = 8'h02;
      else if (!mux[1] && fd == 4'h2) t = 8'h06;
      else if (!mux[1] && fd != 4'h1) t = 8'h08;
      else t = 8'h04;
    end
    return t;
  endfunction

endpackage

// ### lsd_tmr_if.sv
`timescale 1ns/1ns
interface lsd_tmr_if;
  logic       lcd_clock_select;
  logic [1:0] mux;
  logic [3:0] fd;
  logic [1:0] com_idx;
  logic       polarity;
  logic       frame_start;
  modport ctrl  (output lcd_clock_select, output mux, output fd,
                 input com_idx, input polarity, input frame_start);
  modport timer (input lcd_clock_select, input mux, input fd,
                 output com_idx, output polarity, output frame_start);
endinterface

// ### lsd_frame_timer.sv
`timescale 1ns/1ns
module lsd_frame_timer
  import lsd_pkg::*;
#(
  parameter int unsigned FAST_TICK_CYC = LSD_FAST_TICK_CYC,
  parameter int unsigned SLOW_TICK_CYC = LSD_SLOW_TICK_CYC
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  lsd_tmr_if.timer  tmr
);

  logic [LSD_TICK_W-1:0] base_q, base_d, base_lim;
  logic [7:0]            ph_q, ph_d, lat_q, lat_d, div_now;
  logic [1:0]            com_q, com_d, last_com;
  logic                  pol_q, pol_d, frame_q, frame_d;
  logic                  tick, phase_end, frame_end;

  always_comb begin
    base_lim  = tmr.lcd_clock_select ? LSD_TICK_W'(SLOW_TICK_CYC - 1) : LSD_TICK_W'(FAST_TICK_CYC - 1);
    tick      = (base_q >= base_lim);
    base_d    = tick ? '0 : base_q + 1'b1;
    last_com  = lsd_last_com(tmr.mux);
    div_now   = lsd_phase_ticks(tmr.lcd_clock_select, tmr.mux, tmr.fd);
    phase_end = tick && (ph_q == 8'h00);
    frame_end = phase_end && pol_q && (com_q >= last_com);
    // a new divider code only takes effect at a frame edge, never mid-frame
    lat_d     = frame_end ? div_now : lat_q;
    ph_d      = ph_q;
    if (phase_end) ph_d = lat_d - 8'h01;
    else if (tick) ph_d = ph_q - 8'h01;
    pol_d     = phase_end ? ~pol_q : pol_q;
    com_d     = com_q;
    if (phase_end && pol_q) com_d = (com_q >= last_com) ? 2'h0 : com_q + 2'h1;
    frame_d   = frame_end;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      base_q  <= '0;
      ph_q    <= 8'h00;
      lat_q   <= LSD_DIV_RST;
      com_q   <= 2'h0;
      pol_q   <= 1'b0;
      frame_q <= 1'b0;
    end else begin
      base_q  <= base_d;
      ph_q    <= ph_d;
      lat_q   <= lat_d;
      com_q   <= com_d;
      pol_q   <= pol_d;
      frame_q <= frame_d;
    end
  end

  assign tmr.com_idx     = com_q;
  assign tmr.polarity    = pol_q;
  assign tmr.frame_start = frame_q;

  a_inv_phase_toggle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    phase_end |=> (pol_q != $past(pol_q)) ##1 (pol_q == $past(pol_q)))
    else $error("polarity did not flip once per phase");

  a_com_step_pair: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (phase_end && pol_q && (com_q < last_com)) |=> (com_q == $past(com_q) + 2'h1))
    else $error("common line did not advance after two phases");

  a_com_hold_half: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (phase_end && !pol_q) |=> (com_q == $past(com_q)))
    else $error("common line moved in mid waveform period");

  a_frame_reload: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    frame_end |=> (lat_q == $past(div_now)) && (ph_q == lat_q - 8'h01) && frame_q)
    else $error("divider not reloaded at frame edge");

endmodule

// ### lsd_top.sv
`timescale 1ns/1ns
// Functional notes
// - lcd clock 2048 or 128 Hz by bit3
// - rates from clock, mux level, divider code
// - fast clock: sixteen distinct frame rates, fifteen at 3x
// - slow clock 4x: 8, 32, 16 Hz
// - slow clock 2x and 3x rate table
// - common line steps at waveform frequency
// - waveform inverts at twice waveform frequency
// - mux 10/11 turn pins into commons
// - segments 0-15 and 26 always lcd
// - high enable bits 7:2 pick pins 25:20
// - low enable bits 3:0 pick pins 19:16
// - any enable combination, independent per pin
// - pointer write bit7 set stores data
// - eight bit data register, resets zero
// - clear bit wipes segment memory
// - power-on reset wipes segment memory
// - pointer write bit7 clear loads data
// - fifteen bytes, even low, odd high nibble
// - freeze holds display, release next frame
module lsd_top
  import lsd_pkg::*;
#(
  parameter int unsigned FAST_TICK_CYC = LSD_FAST_TICK_CYC,
  parameter int unsigned SLOW_TICK_CYC = LSD_SLOW_TICK_CYC
) (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst,
  input  wire logic [7:0]             i_sfr_addr,
  input  wire logic                   i_sfr_wr,
  input  wire logic [7:0]             i_sfr_wdata,
  input  wire logic                   i_sfr_rd,
  output logic      [7:0]             o_sfr_rdata,
  output logic      [3:0]             o_com_drive,
  output logic      [3:0]             o_com_used,
  output logic      [LSD_NUM_SEG-1:0] o_seg_drive,
  output logic      [LSD_NUM_SEG-1:0] o_seg_lcd_en,
  output logic                        o_pin27_com,
  output logic                        o_pin28_com,
  output logic                        o_wave_polarity,
  output logic                        o_bias_select,
  output logic                        o_frame_start
);

  typedef logic [LSD_MEM_BYTES-1:0][7:0] lsd_mem_t;

  lsd_tmr_if tmr ();

  logic [3:0]       cfg_q, cfg_d;
  logic [3:0]       fd_q, fd_d;
  logic [5:0]       sege_hi_q, sege_hi_d;
  logic [3:0]       sege_lo_q, sege_lo_d;
  logic [7:0]       ptr_q, ptr_d;
  logic [7:0]       dat_q, dat_d;
  logic             frz_q, frz_d;
  logic [7:0]       rdata_q, rdata_d;
  lsd_mem_t         mem_q, mem_d;
  lsd_mem_t         disp_q, disp_d;
  logic [LSD_NUM_SEG-1:0] seg_bit;
  logic [LSD_NUM_SEG-1:0] seg_drv_q, seg_drv_d;
  logic [3:0]       com_drv_q, com_drv_d;
  logic [3:0]       com_use_q, com_use_d;
  logic [1:0]       last_com;
  logic [3:0]       wr_idx;
  logic             wr_ptr, wr_cfg, idx_ok;
  logic [7:0]       mem_rd;
  logic             mem_zero;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  assign wr_idx = i_sfr_wdata[3:0];
  // pointer addresses above 14 fall outside the bank: writes drop, reads return zero
  assign idx_ok = (i_sfr_wdata[5:4] == 2'b00) && (wr_idx <= LSD_LAST_ADDR);
  assign mem_rd = idx_ok ? mem_q[wr_idx] : LSD_REG_RST;
  assign wr_ptr = i_sfr_wr && hit(i_sfr_addr, LSD_ADDR_PTR);
  assign wr_cfg = i_sfr_wr && hit(i_sfr_addr, LSD_ADDR_CFG);

  always_comb begin
    mem_zero = 1'b1;
    for (int i = 0; i < LSD_MEM_BYTES; i++) begin
      if (mem_q[i] != 8'h00) mem_zero = 1'b0;
    end
  end

  // register file and segment memory
  always_comb begin
    cfg_d     = cfg_q;
    fd_d      = fd_q;
    sege_hi_d = sege_hi_q;
    sege_lo_d = sege_lo_q;
    ptr_d     = ptr_q;
    dat_d     = dat_q;
    frz_d     = frz_q;
    mem_d     = mem_q;
    if (i_sfr_wr) begin
      unique case (i_sfr_addr)
        LSD_ADDR_CFG: begin
          // the clear bit is a command and is not stored
          cfg_d = i_sfr_wdata[3:0] & LSD_CFG_MASK[3:0];
          if (i_sfr_wdata[LSD_CFG_CLR_BIT]) mem_d = '0;
        end
        LSD_ADDR_CLK:     fd_d = i_sfr_wdata[3:0] & LSD_FD_MASK[3:0];
        LSD_ADDR_SEGE_HI: sege_hi_d = i_sfr_wdata[7:2];
        LSD_ADDR_SEGE_LO: sege_lo_d = i_sfr_wdata[3:0];
        LSD_ADDR_DAT:     dat_d = i_sfr_wdata;
        LSD_ADDR_FRZ:     frz_d = i_sfr_wdata[0];
        LSD_ADDR_PTR: begin
          ptr_d = i_sfr_wdata & LSD_PTR_MASK;
          if (i_sfr_wdata[LSD_PTR_WR_BIT]) begin
            if (idx_ok) mem_d[wr_idx] = dat_q;
          end else begin
            dat_d = mem_rd;
          end
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    if (i_sfr_rd) begin
      unique case (i_sfr_addr)
        LSD_ADDR_CFG:     rdata_d = {4'h0, cfg_q};
        LSD_ADDR_CLK:     rdata_d = {4'h0, fd_q};
        LSD_ADDR_SEGE_HI: rdata_d = {sege_hi_q, 2'b00} & LSD_SEGE_HI_MASK;
        LSD_ADDR_SEGE_LO: rdata_d = {4'h0, sege_lo_q} & LSD_SEGE_LO_MASK;
        LSD_ADDR_PTR:     rdata_d = ptr_q & LSD_PTR_MASK;
        LSD_ADDR_DAT:     rdata_d = dat_q;
        LSD_ADDR_FRZ:     rdata_d = {7'h00, frz_q} & LSD_FRZ_MASK;
        default:          rdata_d = LSD_REG_RST;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cfg_q     <= 4'h0;
      fd_q      <= 4'h0;
      sege_hi_q <= 6'h00;
      sege_lo_q <= 4'h0;
      ptr_q     <= LSD_REG_RST;
      dat_q     <= LSD_REG_RST;
      frz_q     <= 1'b0;
      rdata_q   <= LSD_REG_RST;
      mem_q     <= '0;
    end else begin
      cfg_q     <= cfg_d;
      fd_q      <= fd_d;
      sege_hi_q <= sege_hi_d;
      sege_lo_q <= sege_lo_d;
      ptr_q     <= ptr_d;
      dat_q     <= dat_d;
      frz_q     <= frz_d;
      rdata_q   <= rdata_d;
      mem_q     <= mem_d;
    end
  end

  assign tmr.lcd_clock_select = cfg_q[LSD_CFG_LCD_CLOCK_SELECT_BIT];
  assign tmr.mux    = cfg_q[1:0];
  assign tmr.fd     = fd_q;

  lsd_frame_timer #(
    .FAST_TICK_CYC (FAST_TICK_CYC),
    .SLOW_TICK_CYC (SLOW_TICK_CYC)
  ) u_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .tmr       (tmr)
  );

  assign last_com = lsd_last_com(cfg_q[1:0]);

  genvar gs;
  generate
    for (gs = 0; gs < LSD_NUM_SEG; gs++) begin : g_seg
      // even segment in the low nibble, odd in the high, one bit per common
      assign seg_bit[gs] = disp_q[gs/2][4*(gs%2) + tmr.com_idx];
    end
  endgenerate

  // display latch and pin drive
  always_comb begin
    // glass sees a new pattern only at a frame edge, so it never tears mid-frame
    disp_d = (tmr.frame_start && !frz_q) ? mem_q : disp_q;
    for (int k = 0; k < 4; k++) begin
      com_use_d[k] = (2'(k) <= last_com);
      com_drv_d[k] = com_use_d[k] & ((tmr.com_idx == 2'(k)) ^ tmr.polarity);
    end
    seg_drv_d = seg_bit ^ {LSD_NUM_SEG{tmr.polarity}};
    if (cfg_q[1]) seg_drv_d[28] = com_drv_d[2];
    if (cfg_q[1:0] == LSD_MUX_4X) seg_drv_d[27] = com_drv_d[3];
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      disp_q    <= '0;
      seg_drv_q <= '0;
      com_drv_q <= 4'h0;
      com_use_q <= 4'h0;
    end else begin
      disp_q    <= disp_d;
      seg_drv_q <= seg_drv_d;
      com_drv_q <= com_drv_d;
      com_use_q <= com_use_d;
    end
  end

  // pins 25:16 keep their alternate function unless their own enable bit is set; pins 28 and 27 become commons by the mux field
  assign o_pin28_com  = cfg_q[1];
  assign o_pin27_com  = (cfg_q[1:0] == LSD_MUX_4X);
  assign o_seg_lcd_en = {~o_pin28_com, ~o_pin27_com, 1'b1, sege_hi_q, sege_lo_q,
                         16'hFFFF};
  assign o_sfr_rdata     = rdata_q;
  assign o_seg_drive     = seg_drv_q;
  assign o_com_drive     = com_drv_q;
  assign o_com_used      = com_use_q;
  assign o_wave_polarity = tmr.polarity;
  // bias only steers the external voltage generator; host must set it first
  assign o_bias_select   = cfg_q[LSD_CFG_BIAS_BIT];
  assign o_frame_start   = tmr.frame_start;

  a_ptr_write_mem: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (wr_ptr && i_sfr_wdata[7] && idx_ok) |=> (mem_q[$past(wr_idx)] == $past(dat_q)))
    else $error("pointer write did not store data byte");

  a_ptr_read_data: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (wr_ptr && !i_sfr_wdata[7]) |=> (dat_q == $past(mem_rd)))
    else $error("pointer read did not load data register");

  a_clear_cmd_mem: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (wr_cfg && i_sfr_wdata[6]) |=> mem_zero)
    else $error("clear command left memory nonzero");

  a_por_mem_zero: assert property (@(posedge i_clk_sys)
    i_rst |=> (mem_zero && (dat_q == 8'h00)))
    else $error("reset left memory or data nonzero");

  a_pin_reassign: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (wr_cfg && (i_sfr_wdata[1:0] == 2'b10)) |=> (o_pin28_com && !o_pin27_com && o_seg_lcd_en[27]))
    else $error("3x mux did not move only pin 28 to common");

  a_fixed_segs: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_seg_lcd_en[15:0] == 16'hFFFF) && o_seg_lcd_en[26])
    else $error("fixed segment lost lcd function");

  a_seg_enable_hi: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sfr_wr && hit(i_sfr_addr, LSD_ADDR_SEGE_HI))
      |=> (o_seg_lcd_en[25:20] == $past(i_sfr_wdata[7:2])))
    else $error("high enable bits not mapped to pins 25:20");

  a_rsvd_read_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sfr_rd && hit(i_sfr_addr, LSD_ADDR_PTR)) |=> (o_sfr_rdata[6] == 1'b0))
    else $error("reserved pointer bit read nonzero");

  a_freeze_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    frz_q |=> $stable(disp_q))
    else $error("display changed while frozen");

  a_seg_enable_lo: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sfr_wr && hit(i_sfr_addr, LSD_ADDR_SEGE_LO))
      |=> (o_seg_lcd_en[19:16] == $past(i_sfr_wdata[3:0])))
    else $error("low enable bits not mapped to pins 19:16");

  a_mux4_pins: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (wr_cfg && (i_sfr_wdata[1:0] == LSD_MUX_4X))
      |=> (o_pin28_com && o_pin27_com && !o_seg_lcd_en[28] && !o_seg_lcd_en[27]))
    else $error("4x mux did not move both shared pins to commons");

  a_mux2_pins: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (wr_cfg && !i_sfr_wdata[1])
      |=> (!o_pin28_com && !o_pin27_com && o_seg_lcd_en[28] && o_seg_lcd_en[27]))
    else $error("2x mux took a shared pin away from segments");

  a_data_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sfr_wr && hit(i_sfr_addr, LSD_ADDR_DAT))
      |=> (dat_q == $past(i_sfr_wdata)))
    else $error("data register did not take written byte");

  a_rsvd_enable_lo: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sfr_rd && hit(i_sfr_addr, LSD_ADDR_SEGE_LO))
      |=> (o_sfr_rdata[7:4] == 4'h0))
    else $error("reserved low enable bits read nonzero");

  a_latch_frame: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (tmr.frame_start && !frz_q)
      |=> (disp_q == $past(mem_q)))
    else $error("display latch missed frame edge copy");

  a_ptr_out_range: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (wr_ptr && i_sfr_wdata[7] && !idx_ok)
      |=> (mem_q == $past(mem_q)))
    else $error("out of range pointer write changed memory");

  a_fd_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_sfr_wr && hit(i_sfr_addr, LSD_ADDR_CLK))
      |=> (tmr.fd == $past(i_sfr_wdata[3:0])))
    else $error("divider code not taken from write");

endmodule

// ### lsd_glass_model.sv
`timescale 1ns/1ns
module lsd_glass_model (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic [3:0]       i_com_drive,
  input  wire logic [3:0]       i_com_used,
  input  wire logic [28:0]      i_seg_drive,
  input  wire logic             i_polarity,
  input  wire logic             i_frame_start,
  output logic      [15:0]      o_frames,
  output logic      [15:0]      o_frame_cyc,
  output logic      [7:0]       o_phases,
  output logic      [28:0][3:0] o_pix
);
  logic        pol_q;
  logic        pol_qq;
  logic        tog;
  logic [15:0] cyc_q;
  logic [7:0]  tog_q;

  assign tog = i_polarity != pol_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pol_q       <= 1'b0;
      pol_qq      <= 1'b0;
      cyc_q       <= 16'h0000;
      tog_q       <= 8'h00;
      o_frames    <= 16'h0000;
      o_frame_cyc <= 16'h0000;
      o_phases    <= 8'h00;
      o_pix       <= '0;
    end else begin
      pol_q  <= i_polarity;
      pol_qq <= pol_q;
      if (i_frame_start) begin
        o_frames    <= o_frames + 16'h0001;
        o_frame_cyc <= cyc_q + 16'h0001;
        o_phases    <= tog_q + {7'h00, tog};
        cyc_q       <= 16'h0000;
        tog_q       <= 8'h00;
      end else begin
        cyc_q <= cyc_q + 16'h0001;
        tog_q <= tog_q + {7'h00, tog};
      end
      // sample only once polarity has settled, so drive skew around a phase edge is ignored
      if (i_polarity == pol_q && pol_q == pol_qq) begin
        for (int k = 0; k < 4; k++) begin
          if (i_com_used[k] && i_com_drive[k] != i_polarity) begin
            for (int s = 0; s < 29; s++) begin
              o_pix[s][k] <= i_seg_drive[s] ^ i_polarity;
            end
          end
        end
      end
    end
  end
endmodule

// ### tb.sv
`timescale 1ns/1ns
module tb;
  import lsd_pkg::*;
  localparam int FT = 4;
  localparam int ST = 8;
  logic             i_clk_sys;
  logic             i_rst;
  logic [7:0]       i_sfr_addr;
  logic             i_sfr_wr;
  logic [7:0]       i_sfr_wdata;
  logic             i_sfr_rd;
  logic [7:0]       o_sfr_rdata;
  logic [3:0]       o_com_drive;
  logic [3:0]       o_com_used;
  logic [28:0]      o_seg_drive;
  logic [28:0]      o_seg_lcd_en;
  logic             o_pin27_com;
  logic             o_pin28_com;
  logic             o_wave_polarity;
  logic             o_bias_select;
  logic             o_frame_start;
  logic [15:0]      frames;
  logic [15:0]      frame_cyc;
  logic [7:0]       phases;
  logic [28:0][3:0] pix;
  int               errors;
  int               comparisons;
  // {cfg, divider code, frame length in ticks}
  logic [31:0] cases [16] = '{32'h00091010, 32'h00092018, 32'h00093020, 32'h0009E020,
                              32'h0009F004, 32'h00090008, 32'h00086020, 32'h000A5018,
                              32'h000AF006, 32'h000A000C, 32'h000B1020, 32'h000BE020,
                              32'h000BF008, 32'h000B0010, 32'h00013040, 32'h00023030};

  lsd_top #(.FAST_TICK_CYC(FT), .SLOW_TICK_CYC(ST)) i_lsd_top (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
    .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata),
    .o_com_drive(o_com_drive), .o_com_used(o_com_used), .o_seg_drive(o_seg_drive),
    .o_seg_lcd_en(o_seg_lcd_en), .o_pin27_com(o_pin27_com), .o_pin28_com(o_pin28_com),
    .o_wave_polarity(o_wave_polarity), .o_bias_select(o_bias_select),
    .o_frame_start(o_frame_start));

  lsd_glass_model i_lsd_glass_model (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_com_drive(o_com_drive), .i_com_used(o_com_used),
    .i_seg_drive(o_seg_drive), .i_polarity(o_wave_polarity), .i_frame_start(o_frame_start),
    .o_frames(frames), .o_frame_cyc(frame_cyc), .o_phases(phases), .o_pix(pix));

  initial i_clk_sys = 1'b0;
  always #4 i_clk_sys = ~i_clk_sys;

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_sfr_addr  <= a;
    i_sfr_wdata <= d;
    i_sfr_wr    <= 1'b1;
    @(posedge i_clk_sys);
    i_sfr_wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_sfr_addr <= a;
    i_sfr_rd   <= 1'b1;
    @(posedge i_clk_sys);
    i_sfr_rd <= 1'b0;
    #1;
    chk(what, {24'h0, exp}, {24'h0, o_sfr_rdata});
  endtask

  task automatic do_reset();
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic wait_frames(input int n);
    int          lim;
    logic [15:0] f0;
    f0 = frames;
    for (lim = 0; lim < 20000 && int'(frames - f0) < n; lim++) @(posedge i_clk_sys);
    if (lim == 20000) begin
      errors++;
      $display("BAD frame wait expected %0d frames seen %0d", n, int'(frames - f0));
      print_verdict();
    end else begin
      #1;
    end
  endtask

  task automatic rate(input logic [7:0] cfg, input logic [3:0] fd, input int ticks);
    int nc;
    nc = cfg[1] ? (cfg[0] ? 4 : 3) : 2;
    wr(LSD_ADDR_CFG, cfg);
    wr(LSD_ADDR_CLK, {4'h0, fd});
    // three frames: a boundary may fall between the two writes
    wait_frames(3);
    chk("frame cycles", ticks * (cfg[3] ? ST : FT), {16'h0, frame_cyc});
    chk("phases per frame", 2 * nc, {24'h0, phases});
  endtask

  initial begin
    i_rst       = 1'b1;
    i_sfr_addr  = 8'h00;
    i_sfr_wr    = 1'b0;
    i_sfr_wdata = 8'h00;
    i_sfr_rd    = 1'b0;
    errors      = 0;
    comparisons = 0;
    do_reset();
    rd_chk("seg enable high", LSD_ADDR_SEGE_HI, 8'h00);
    rd_chk("seg enable low", LSD_ADDR_SEGE_LO, 8'h00);
    rd_chk("pointer", LSD_ADDR_PTR, 8'h00);
    rd_chk("data", LSD_ADDR_DAT, 8'h00);
    rd_chk("unmapped", 8'h10, 8'h00);
    settle();
    chk("lcd enables", 32'h1C00FFFF, {3'h0, o_seg_lcd_en});
    chk("pin muxing", 32'h0, {30'h0, o_pin27_com, o_pin28_com});
    wr(LSD_ADDR_SEGE_HI, 8'hA7);
    wr(LSD_ADDR_SEGE_LO, 8'hF5);
    wr(LSD_ADDR_CFG, 8'h02);
    rd_chk("seg enable high", LSD_ADDR_SEGE_HI, 8'hA4);
    rd_chk("seg enable low", LSD_ADDR_SEGE_LO, 8'h05);
    settle();
    chk("lcd enables", 32'h0E95FFFF, {3'h0, o_seg_lcd_en});
    chk("pin muxing", 32'h1, {30'h0, o_pin27_com, o_pin28_com});
    chk("commons used", 32'h7, {28'h0, o_com_used});
    wr(LSD_ADDR_CFG, 8'h07);
    wr(LSD_ADDR_CLK, 8'h01);
    settle();
    chk("lcd enables", 32'h0695FFFF, {3'h0, o_seg_lcd_en});
    chk("pin muxing", 32'h3, {30'h0, o_pin27_com, o_pin28_com});
    chk("commons used", 32'hF, {28'h0, o_com_used});
    chk("bias", 32'h1, {31'h0, o_bias_select});
    wr(LSD_ADDR_DAT, 8'hA5);
    wr(LSD_ADDR_PTR, 8'h80);
    wr(LSD_ADDR_DAT, 8'h3C);
    wr(LSD_ADDR_PTR, 8'h8D);
    rd_chk("pointer", LSD_ADDR_PTR, 8'h8D);
    wr(LSD_ADDR_PTR, 8'h00);
    rd_chk("byte 0", LSD_ADDR_DAT, 8'hA5);
    wr(LSD_ADDR_PTR, 8'h4D);
    rd_chk("pointer", LSD_ADDR_PTR, 8'h0D);
    rd_chk("byte 13", LSD_ADDR_DAT, 8'h3C);
    wr(LSD_ADDR_PTR, 8'hBF);
    wr(LSD_ADDR_PTR, 8'h3F);
    rd_chk("beyond memory", LSD_ADDR_DAT, 8'h00);
    wait_frames(3);
    chk("seg0 pixels", 32'h5, {28'h0, pix[0]});
    chk("seg1 pixels", 32'hA, {28'h0, pix[1]});
    chk("seg26 pixels", 32'hC, {28'h0, pix[26]});
    wr(LSD_ADDR_FRZ, 8'h01);
    wr(LSD_ADDR_DAT, 8'h00);
    wr(LSD_ADDR_PTR, 8'h80);
    wait_frames(3);
    chk("frozen seg0", 32'h5, {28'h0, pix[0]});
    wr(LSD_ADDR_FRZ, 8'h00);
    wait_frames(3);
    chk("released seg0", 32'h0, {28'h0, pix[0]});
    chk("released seg1", 32'h0, {28'h0, pix[1]});
    wr(LSD_ADDR_CFG, 8'h47);
    rd_chk("config", LSD_ADDR_CFG, 8'h07);
    wr(LSD_ADDR_PTR, 8'h0D);
    rd_chk("cleared byte 13", LSD_ADDR_DAT, 8'h00);
    wr(LSD_ADDR_DAT, 8'h5A);
    wr(LSD_ADDR_PTR, 8'h81);
    do_reset();
    wr(LSD_ADDR_PTR, 8'h01);
    rd_chk("byte 1 after reset", LSD_ADDR_DAT, 8'h00);
    for (int fd = 0; fd < 16; fd++) begin
      rate(8'h03, fd[3:0], (fd == 0) ? 512 : 16 * (fd + 1));
    end
    for (int i = 0; i < 16; i++) begin
      rate(cases[i][23:16], cases[i][15:12], int'(cases[i][11:0]));
    end
    print_verdict();
  end
endmodule
